/* File: uurb_params.svh */
// timing-free constants for the channel register bank
// Behaviour
// - Every bank register except revision and link status is reached by the vendor register requests.
// - Revision is only read by its own request and link status only by its own set and get requests.
// - Each register is 16 bits wide and moves as one 16-bit value per access.
// - The upper byte of byte registers and every fixed-zero position is reserved.
// - In the enable register bit 1 enables the receiver, bit 0 the transmitter, both zero at reset.
// - The error register gathers four line error events since its last read, and a read clears them; break status is shown live.
// - Register address travels in index low byte, channel in index high byte, 0 for the first UART and 2 for the second.
`ifndef UURB_PARAMS_SVH
`define UURB_PARAMS_SVH
`define UURB_RT_VWR 8'h41
`define UURB_RT_VRD 8'hC1
`define UURB_RT_DEV_IN 8'hC0
`define UURB_RT_DEV_OUT 8'h40
`define UURB_RQ_VENDOR 8'h00
`define UURB_IX_REV 16'h0260
`define UURB_IX_LINK 16'h0262
`define UURB_CH_A 8'h00
`define UURB_CH_B 8'h02
`define UURB_LINK_MASK 16'h3F3F
`define UURB_A_ENABLE 8'h00
`define UURB_A_FLOW 8'h06
`define UURB_A_XON 8'h07
`define UURB_A_XOFF 8'h08
`define UURB_A_ERR 8'h09
`define UURB_A_BREAK 8'h0A
`define UURB_A_XCVR 8'h0B
`define UURB_A_PMODE 8'h0C
`define UURB_A_PDIR 8'h0D
`define UURB_A_PSET 8'h0E
`define UURB_A_PCLR 8'h0F
`define UURB_A_PLVL 8'h10
`define UURB_A_PIMSK 8'h11
`define UURB_A_CEVT 8'h12
`define UURB_A_POD 8'h13
`define UURB_A_PUP 8'h14
`define UURB_A_PDN 8'h15
`define UURB_A_LOOP 8'h16
`define UURB_A_IR 8'h17
`define UURB_A_CKDIV 8'h18
`define UURB_A_WAKE 8'h1F
`define UURB_A_TXFL 8'h40
`define UURB_A_TXCNT 8'h41
`define UURB_A_TXWIDE 8'h42
`define UURB_A_RXFL 8'h43
`define UURB_A_RXCNT 8'h44
`define UURB_A_RXWIDE 8'h45
`define UURB_A_LOWLAT 8'h46
`define UURB_A_RXTHR 8'h47
`define UURB_A_DRV 8'h60
`define UURB_A_SLPLV 8'h6A
`define UURB_A_SLPOV 8'h6B
`define UURB_NSLOT 26
`define UURB_RST_XON 16'h0011
`define UURB_RST_XOFF 16'h0013
`define UURB_RST_ZERO 16'h0000
`define UURB_REV_DEFAULT 16'h0001
`endif

/* File: uurb_pkg.sv */
// types shared by the channel register bank
package uurb_pkg;
	typedef struct packed {
		logic valid;
		logic [7:0] rtype;
		logic [7:0] code;
		logic [15:0] value;
		logic [15:0] index;
	} uurb_req_t;
	typedef struct packed {
		logic valid;
		logic ack;
		logic [15:0] data;
	} uurb_rsp_t;
	typedef struct packed {
		logic [9:0] tx_cnt;
		logic [9:0] rx_cnt;
		logic [11:0] pin_level;
		logic [3:0] err_ev;
		logic break_live;
	} uurb_line_t;
	typedef struct packed {
		logic tx_en;
		logic rx_en;
		logic half_duplex;
		logic [2:0] flow_mode;
		logic [7:0] xon;
		logic [7:0] xoff;
		logic [15:0] break_len;
		logic [9:0] pin_out;
		logic [9:0] pin_dir;
		logic [15:0] clk_div;
		logic [2:0] tx_flush;
		logic [2:0] rx_flush;
		logic [9:0] rx_thresh;
	} uurb_ctrl_t;
	typedef enum logic [2:0] {
		UURB_K_NONE, UURB_K_VWR, UURB_K_VRD, UURB_K_REV, UURB_K_LWR,
		UURB_K_LRD
	} uurb_kind_t;
endpackage

/* File: uurb_err_accum.sv */
// sticky line error flags with clear on read
`timescale 1ns/1ps
`include "uurb_params.svh"
module uurb_err_accum (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [3:0] err_ev,
	input wire logic break_live,
	input wire logic rd_clr,
	output logic [15:0] rd_val
);
	logic [3:0] sticky_reg;
	logic [3:0] sticky_next;

	// a new event in the clearing cycle survives
	always_comb begin
		sticky_next = sticky_reg;
		if (rd_clr) begin
			sticky_next = 4'h0;
		end
		sticky_next = sticky_next | err_ev;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			sticky_reg <= 4'h0;
		end else begin
			sticky_reg <= sticky_next;
		end
	end

	// break status is live, the rest historical; low bits reserved
	assign rd_val = {8'h00, break_live, sticky_reg, 3'h0};

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_clear_on_read;
		rd_clr && err_ev == 4'h0 |=> sticky_reg == 4'h0;
	endproperty
	a_clear_on_read: assert property (p_clear_on_read)
		else $error("error flags not cleared by read");
	property p_set_wins;
		rd_clr && err_ev[0] |=> sticky_reg[0];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("event lost while clearing");
endmodule

/* File: uurb_chan_regs.sv */
// register set of one UART channel
`timescale 1ns/1ps
`include "uurb_params.svh"
module uurb_chan_regs (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic wr_pulse,
	input wire logic rd_pulse,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire uurb_pkg::uurb_line_t line,
	output logic [15:0] rdata,
	output uurb_pkg::uurb_ctrl_t ctrl
);
	// slot number of a storage register, or NSLOT when none
	function automatic logic [4:0] slot_of(input logic [7:0] a);
		case (a)
			`UURB_A_ENABLE: slot_of = 5'd0;
			`UURB_A_FLOW: slot_of = 5'd1;
			`UURB_A_XON: slot_of = 5'd2;
			`UURB_A_XOFF: slot_of = 5'd3;
			`UURB_A_BREAK: slot_of = 5'd4;
			`UURB_A_XCVR: slot_of = 5'd5;
			`UURB_A_PMODE: slot_of = 5'd6;
			`UURB_A_PDIR: slot_of = 5'd7;
			`UURB_A_PIMSK: slot_of = 5'd8;
			`UURB_A_CEVT: slot_of = 5'd9;
			`UURB_A_POD: slot_of = 5'd10;
			`UURB_A_PUP: slot_of = 5'd11;
			`UURB_A_PDN: slot_of = 5'd12;
			`UURB_A_LOOP: slot_of = 5'd13;
			`UURB_A_IR: slot_of = 5'd14;
			`UURB_A_CKDIV: slot_of = 5'd15;
			`UURB_A_WAKE: slot_of = 5'd16;
			`UURB_A_TXFL: slot_of = 5'd17;
			`UURB_A_TXWIDE: slot_of = 5'd18;
			`UURB_A_RXFL: slot_of = 5'd19;
			`UURB_A_RXWIDE: slot_of = 5'd20;
			`UURB_A_LOWLAT: slot_of = 5'd21;
			`UURB_A_RXTHR: slot_of = 5'd22;
			`UURB_A_DRV: slot_of = 5'd23;
			`UURB_A_SLPLV: slot_of = 5'd24;
			`UURB_A_SLPOV: slot_of = 5'd25;
			default: slot_of = 5'(`UURB_NSLOT);
		endcase
	endfunction

	// implemented bits of each slot, by slot number
	function automatic logic [15:0] mask_of(input logic [4:0] s);
		case (s)
			5'd0: mask_of = 16'h0003;
			5'd1: mask_of = 16'h000F;
			5'd2, 5'd3: mask_of = 16'h00FF;
			5'd4, 5'd15: mask_of = 16'hFFFF;
			5'd5: mask_of = 16'h000F;
			5'd6, 5'd7, 5'd22: mask_of = 16'h03FF;
			5'd8, 5'd11, 5'd12: mask_of = 16'h07FF;
			5'd9: mask_of = 16'h0003;
			5'd10: mask_of = 16'h0BFF;
			5'd13, 5'd14, 5'd17, 5'd19: mask_of = 16'h0007;
			5'd16: mask_of = 16'h000C;
			5'd18, 5'd20, 5'd21, 5'd23: mask_of = 16'h0001;
			5'd24: mask_of = 16'h3CCF;
			5'd25: mask_of = 16'hBCCF;
			default: mask_of = 16'h0000;
		endcase
	endfunction

	logic [15:0] cfg_reg [`UURB_NSLOT];
	logic [15:0] cfg_next [`UURB_NSLOT];
	logic [9:0] pin_out_reg;
	logic [9:0] pin_out_next;
	logic [4:0] slot;
	logic [15:0] err_val;

	assign slot = slot_of(addr);

	uurb_err_accum u_err (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.err_ev(line.err_ev),
		.break_live(line.break_live),
		.rd_clr(rd_pulse && addr == `UURB_A_ERR),
		.rd_val(err_val)
	);

	// storage update; reserved positions never hold a one
	always_comb begin
		for (int i = 0; i < `UURB_NSLOT; i++) begin
			cfg_next[i] = cfg_reg[i];
		end
		pin_out_next = pin_out_reg;
		if (wr_pulse && slot != 5'(`UURB_NSLOT)) begin
			cfg_next[slot] = wdata & mask_of(slot);
		end
		if (wr_pulse && addr == `UURB_A_PSET) begin
			pin_out_next = pin_out_reg | wdata[9:0];
		end
		if (wr_pulse && addr == `UURB_A_PCLR) begin
			pin_out_next = pin_out_reg & ~wdata[9:0];
		end
	end

	// character defaults differ from zero, all else clears
	generate
		for (genvar g = 0; g < `UURB_NSLOT; g++) begin : g_slot
			always_ff @(posedge sys_clk) begin
				if (!rst_b) begin
					if (g == 2) begin
						cfg_reg[g] <= `UURB_RST_XON;
					end else if (g == 3) begin
						cfg_reg[g] <= `UURB_RST_XOFF;
					end else begin
						cfg_reg[g] <= `UURB_RST_ZERO;
					end
				end else begin
					cfg_reg[g] <= cfg_next[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			pin_out_reg <= 10'h000;
		end else begin
			pin_out_reg <= pin_out_next;
		end
	end

	// read mux; write-only and unknown addresses give zero
	always_comb begin
		case (addr)
			`UURB_A_ERR: rdata = err_val;
			`UURB_A_PLVL: rdata = {4'h0, line.pin_level};
			`UURB_A_TXCNT: rdata = {6'h00, line.tx_cnt};
			`UURB_A_RXCNT: rdata = {6'h00, line.rx_cnt};
			default: begin
				if (slot != 5'(`UURB_NSLOT)) begin
					rdata = cfg_reg[slot];
				end else begin
					rdata = 16'h0000;
				end
			end
		endcase
	end

	// control view for the UART datapath
	assign ctrl.tx_en = cfg_reg[0][0];
	assign ctrl.rx_en = cfg_reg[0][1];
	assign ctrl.half_duplex = cfg_reg[1][3];
	assign ctrl.flow_mode = cfg_reg[1][2:0];
	assign ctrl.xon = cfg_reg[2][7:0];
	assign ctrl.xoff = cfg_reg[3][7:0];
	assign ctrl.break_len = cfg_reg[4];
	assign ctrl.pin_out = pin_out_reg;
	assign ctrl.pin_dir = cfg_reg[7][9:0];
	assign ctrl.clk_div = cfg_reg[15];
	assign ctrl.tx_flush = cfg_reg[17][2:0];
	assign ctrl.rx_flush = cfg_reg[19][2:0];
	assign ctrl.rx_thresh = cfg_reg[22][9:0];

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_reserved_zero;
		(cfg_reg[0] & ~mask_of(5'd0)) == 16'h0000
			&& (cfg_reg[25] & ~mask_of(5'd25)) == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bit holds a one");
	property p_pin_set;
		wr_pulse && addr == `UURB_A_PSET |=>
			(pin_out_reg & $past(wdata[9:0])) == $past(wdata[9:0]);
	endproperty
	a_pin_set: assert property (p_pin_set)
		else $error("pin set not applied");
endmodule

/* File: uurb_bank.sv */
// two-channel register bank behind the vendor control requests
`timescale 1ns/1ps
`include "uurb_params.svh"
module uurb_bank #(
	// revision value; arbitrary
	parameter logic [15:0] REV_VALUE = `UURB_REV_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire uurb_pkg::uurb_req_t req,
	input wire uurb_pkg::uurb_line_t line [2],
	output uurb_pkg::uurb_rsp_t rsp,
	output logic [15:0] link_status,
	output uurb_pkg::uurb_ctrl_t ctrl [2]
);
	////////////////////////////////////////////////////////////////////
	// request decoding

	// classify a setup packet; dedicated indexes win for device requests
	function automatic uurb_pkg::uurb_kind_t kind_of(
		input uurb_pkg::uurb_req_t r);
		kind_of = uurb_pkg::UURB_K_NONE;
		if (r.valid && r.code == `UURB_RQ_VENDOR) begin
			case (r.rtype)
				`UURB_RT_VWR: kind_of = uurb_pkg::UURB_K_VWR;
				`UURB_RT_VRD: kind_of = uurb_pkg::UURB_K_VRD;
				`UURB_RT_DEV_IN: begin
					if (r.index == `UURB_IX_REV) begin
						kind_of = uurb_pkg::UURB_K_REV;
					end else if (r.index == `UURB_IX_LINK) begin
						kind_of = uurb_pkg::UURB_K_LRD;
					end
				end
				`UURB_RT_DEV_OUT: begin
					if (r.index == `UURB_IX_LINK) begin
						kind_of = uurb_pkg::UURB_K_LWR;
					end
				end
				default: kind_of = uurb_pkg::UURB_K_NONE;
			endcase
		end
	endfunction

	uurb_pkg::uurb_kind_t kind;
	logic [1:0] ch_hit;
	logic [1:0] ch_wr;
	logic [1:0] ch_rd;
	logic [15:0] ch_rdata [2];

	assign kind = kind_of(req);

	// channel from index high byte; any other code hits nothing
	assign ch_hit[0] = req.index[15:8] == `UURB_CH_A;
	assign ch_hit[1] = req.index[15:8] == `UURB_CH_B;
	assign ch_wr = (kind == uurb_pkg::UURB_K_VWR) ? ch_hit : 2'b00;
	assign ch_rd = (kind == uurb_pkg::UURB_K_VRD) ? ch_hit : 2'b00;

	////////////////////////////////////////////////////////////////////
	// channel register sets

	generate
		for (genvar c = 0; c < 2; c++) begin : g_ch
			uurb_chan_regs u_regs (
				.sys_clk(sys_clk),
				.rst_b(rst_b),
				.wr_pulse(ch_wr[c]),
				.rd_pulse(ch_rd[c]),
				.addr(req.index[7:0]),
				.wdata(req.value),
				.line(line[c]),
				.rdata(ch_rdata[c]),
				.ctrl(ctrl[c])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// answer and link status

	uurb_pkg::uurb_rsp_t rsp_reg;
	uurb_pkg::uurb_rsp_t rsp_next;
	logic [15:0] link_reg;
	logic [15:0] link_next;

	// one answer per request, the cycle after it; unknown ones are nacked
	always_comb begin
		rsp_next = '0;
		link_next = link_reg;
		rsp_next.valid = req.valid;
		case (kind)
			uurb_pkg::UURB_K_VWR: begin
				rsp_next.ack = 1'b1;
			end
			uurb_pkg::UURB_K_VRD: begin
				rsp_next.ack = 1'b1;
				if (ch_hit[0]) begin
					rsp_next.data = ch_rdata[0];
				end else if (ch_hit[1]) begin
					rsp_next.data = ch_rdata[1];
				end else begin
					rsp_next.data = 16'h0000;
				end
			end
			uurb_pkg::UURB_K_REV: begin
				rsp_next.ack = 1'b1;
				rsp_next.data = REV_VALUE;
			end
			uurb_pkg::UURB_K_LWR: begin
				rsp_next.ack = 1'b1;
				link_next = req.value & `UURB_LINK_MASK;
			end
			uurb_pkg::UURB_K_LRD: begin
				rsp_next.ack = 1'b1;
				rsp_next.data = link_reg;
			end
			default: begin
				rsp_next.ack = 1'b0;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			rsp_reg <= '0;
			link_reg <= 16'h0000;
		end else begin
			rsp_reg <= rsp_next;
			link_reg <= link_next;
		end
	end

	assign rsp = rsp_reg;
	assign link_status = link_reg;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_wr_enable_a;
		kind == uurb_pkg::UURB_K_VWR && ch_hit[0]
			&& req.index[7:0] == `UURB_A_ENABLE;
	endsequence
	sequence s_rd_enable_a;
		kind == uurb_pkg::UURB_K_VRD && ch_hit[0]
			&& req.index[7:0] == `UURB_A_ENABLE;
	endsequence

	property p_answer_next;
		req.valid |=> rsp.valid ##1 !rsp.valid || $past(req.valid);
	endproperty
	a_answer_next: assert property (p_answer_next)
		else $error("answer not one cycle after request");

	property p_enable_bits;
		s_wr_enable_a |=> ctrl[0].tx_en == $past(req.value[0])
			&& ctrl[0].rx_en == $past(req.value[1]);
	endproperty
	a_enable_bits: assert property (p_enable_bits)
		else $error("enable bits do not follow write");

	// requests come with an idle cycle between them
	property p_enable_readback;
		s_wr_enable_a ##1 !req.valid ##1 s_rd_enable_a |=>
			rsp.data == {14'h0000, $past(req.value[1:0], 3)};
	endproperty
	a_enable_readback: assert property (p_enable_readback)
		else $error("enable read back differs");

	property p_bad_channel_zero;
		kind == uurb_pkg::UURB_K_VRD && ch_hit == 2'b00 |=>
			rsp.ack && rsp.data == 16'h0000;
	endproperty
	a_bad_channel_zero: assert property (p_bad_channel_zero)
		else $error("bad channel read not zero");

	property p_revision;
		kind == uurb_pkg::UURB_K_REV |=> rsp.data == REV_VALUE;
	endproperty
	a_revision: assert property (p_revision)
		else $error("revision value wrong");

	property p_link_untouched;
		kind == uurb_pkg::UURB_K_VWR |=> $stable(link_status);
	endproperty
	a_link_untouched: assert property (p_link_untouched)
		else $error("generic write changed link status");

	property p_channel_isolated;
		kind == uurb_pkg::UURB_K_VWR && ch_hit[1] |=> $stable(ctrl[0]);
	endproperty
	a_channel_isolated: assert property (p_channel_isolated)
		else $error("second channel write hit first");

	property p_link_masked;
		kind == uurb_pkg::UURB_K_LWR |=>
			link_status == ($past(req.value) & `UURB_LINK_MASK);
	endproperty
	a_link_masked: assert property (p_link_masked)
		else $error("link status reserved bits stored");

	sequence s_rd_err_a;
		kind == uurb_pkg::UURB_K_VRD && ch_hit[0]
			&& req.index[7:0] == `UURB_A_ERR;
	endsequence

	// unknown requests stall with no data
	property p_nack_unknown;
		req.valid && kind == uurb_pkg::UURB_K_NONE |=>
			rsp.valid && !rsp.ack && rsp.data == 16'h0000;
	endproperty
	a_nack_unknown: assert property (p_nack_unknown)
		else $error("unknown request not stalled");

	// writes answer with zero data
	property p_write_no_data;
		kind == uurb_pkg::UURB_K_VWR |=> rsp.ack && rsp.data == 16'h0000;
	endproperty
	a_write_no_data: assert property (p_write_no_data)
		else $error("write answer carries data");

	// no answer without a request
	property p_idle_quiet;
		!req.valid |=> !rsp.valid;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet)
		else $error("answer without request");

	// only the dedicated write moves link status
	property p_link_hold;
		kind != uurb_pkg::UURB_K_LWR |=> $stable(link_status);
	endproperty
	a_link_hold: assert property (p_link_hold)
		else $error("link status changed without its request");

	property p_link_read;
		kind == uurb_pkg::UURB_K_LRD |=> rsp.data == $past(link_status);
	endproperty
	a_link_read: assert property (p_link_read)
		else $error("link status read wrong");

	property p_link_reserved;
		link_status[15:14] == 2'b00 && link_status[7:6] == 2'b00;
	endproperty
	a_link_reserved: assert property (p_link_reserved)
		else $error("link status reserved bit set");

	property p_channel_isolated_b;
		kind == uurb_pkg::UURB_K_VWR && ch_hit[0] |=> $stable(ctrl[1]);
	endproperty
	a_channel_isolated_b: assert property (p_channel_isolated_b)
		else $error("first channel write hit second");

	// a channel byte other than 0 or 2 touches nothing
	property p_bad_channel_write;
		kind == uurb_pkg::UURB_K_VWR && ch_hit == 2'b00 |=>
			$stable(ctrl[0]) && $stable(ctrl[1]);
	endproperty
	a_bad_channel_write: assert property (p_bad_channel_write)
		else $error("bad channel write changed state");

	property p_enable_hold;
		!s_wr_enable_a |=> $stable({ctrl[0].tx_en, ctrl[0].rx_en});
	endproperty
	a_enable_hold: assert property (p_enable_hold)
		else $error("enables moved without a write");

	property p_err_reserved;
		s_rd_err_a |=> rsp.data[15:8] == 8'h00 && rsp.data[2:0] == 3'h0;
	endproperty
	a_err_reserved: assert property (p_err_reserved)
		else $error("error register reserved bits set");

	property p_read_ack;
		kind == uurb_pkg::UURB_K_VRD |=> rsp.valid && rsp.ack;
	endproperty
	a_read_ack: assert property (p_read_ack)
		else $error("generic read not acknowledged");
endmodule

/* File: uurb_host_model.sv */
// host-side vendor request issuer facing the register bank
`timescale 1ns/1ps
module uurb_host_model (
	input wire logic sys_clk,
	output uurb_pkg::uurb_req_t req,
	input wire uurb_pkg::uurb_rsp_t rsp
);
	// idle until the first request
	initial begin
		req = '0;
	end
	////////////////////////////////////////////////////////////////////////
	// one setup packet; the answer stands only in the next cycle
	task automatic xfer(input logic [7:0] rt, input logic [15:0] ix,
		input logic [15:0] v, output uurb_pkg::uurb_rsp_t r);
		@(posedge sys_clk);
		#2;
		req = '{1'b1, rt, 8'h00, v, ix};
		@(posedge sys_clk);
		#2;
		r = rsp;
		// released fields flip so a stale value never looks valid
		req = '{1'b0, ~rt, 8'hFF, ~v, ~ix};
	endtask
endmodule

/* File: uurb_bank_bench.sv */
// self-checking bench for the two-channel register bank
`timescale 1ns/1ps
`include "uurb_params.svh"
`define TB_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module uurb_bank_bench;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	uurb_pkg::uurb_req_t req;
	uurb_pkg::uurb_line_t line [2];
	uurb_pkg::uurb_rsp_t rsp;
	logic [15:0] link_status;
	uurb_pkg::uurb_ctrl_t ctrl [2];
	uurb_pkg::uurb_rsp_t r;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [15:0] lfsr = 16'h9521;
	logic [15:0] v;
	logic [15:0] ix;
	logic [7:0] a;
	logic [7:0] chb;
	logic [7:0] xb;
	logic [3:0] ev;
	logic [15:0] drv_b;
	// read-write registers whose fields hold plain data
	logic [7:0] rw_addr [22] = '{8'h06, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0C,
		8'h0D, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h1F,
		8'h42, 8'h45, 8'h46, 8'h47, 8'h60, 8'h6A, 8'h6B};
	localparam logic [15:0] REV = 16'h5A3C; // arbitrary revision value

	uurb_bank #(.REV_VALUE(REV)) u_uurb_bank (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.req(req),
		.line(line),
		.rsp(rsp),
		.link_status(link_status),
		.ctrl(ctrl)
	);
	uurb_host_model u_uurb_host_model (
		.sys_clk(sys_clk),
		.req(req),
		.rsp(rsp)
	);

	// 50 ns period
	always #25 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////////////
	// lfsr so every run sees the same values
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	// writable bits; reserved positions read back as zero
	function automatic logic [15:0] mask_of(input logic [7:0] ad);
		case (ad)
			8'h06, 8'h0B: mask_of = 16'h000F;
			8'h07, 8'h08: mask_of = 16'h00FF;
			8'h0A: mask_of = 16'hFFFF;
			8'h0C, 8'h0D, 8'h47: mask_of = 16'h03FF;
			8'h11, 8'h14, 8'h15: mask_of = 16'h07FF;
			8'h12: mask_of = 16'h0003;
			8'h13: mask_of = 16'h0BFF;
			8'h16, 8'h17: mask_of = 16'h0007;
			8'h1F: mask_of = 16'h000C;
			8'h6A: mask_of = 16'h3CCF;
			8'h6B: mask_of = 16'hBCCF;
			default: mask_of = 16'h0001;
		endcase
	endfunction
	function automatic logic [15:0] rst_of(input logic [7:0] ad);
		if (ad == `UURB_A_XON) begin
			return `UURB_RST_XON;
		end
		return (ad == `UURB_A_XOFF) ? `UURB_RST_XOFF : `UURB_RST_ZERO;
	endfunction
	////////////////////////////////////////////////////////////////////////
	// one request; every request is answered after one cycle
	task automatic go(input logic [7:0] rt, input logic [15:0] i,
		input logic [15:0] wv);
		u_uurb_host_model.xfer(rt, i, wv, r);
		`TB_CHK("rsp_valid", 1'b1, r.valid)
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// hang guard, far beyond the 159 transfers planned
	initial begin
		#(50 * 8000);
		n_mismatch++;
		print_verdict();
	end
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		line[0] = '0;
		line[1] = '0;
		repeat (6) @(posedge sys_clk);
		#2;
		rst_b = 1'b1;
		for (int c = 0; c < 2; c++) begin
			line[c].tx_cnt = 10'(rnd());
			line[c].rx_cnt = 10'(rnd());
			line[c].pin_level = 12'(rnd());
		end
		// uart off at reset; stays off while registers change
		go(`UURB_RT_VRD, {`UURB_CH_A, `UURB_A_ENABLE}, 16'h0000);
		`TB_CHK("enable_rst", 16'h0000, r.data)
		`TB_CHK("tx_en_rst", 1'b0, ctrl[0].tx_en)
		for (int c = 0; c < 2; c++) begin
			chb = (c != 0) ? `UURB_CH_B : `UURB_CH_A;
			for (int i = 0; i < 22; i++) begin
				a = rw_addr[i];
				ix = {chb, a};
				go(`UURB_RT_VRD, ix, 16'h0000);
				`TB_CHK("reset", rst_of(a), r.data)
				v = rnd() & mask_of(a);
				go(`UURB_RT_VWR, ix, v);
				go(`UURB_RT_VRD, ix, 16'h0000);
				`TB_CHK("readback", v & mask_of(a), r.data)
				if (a == `UURB_A_XON) begin
					`TB_CHK("xon", v[7:0], ctrl[c].xon)
				end
				if (a == `UURB_A_BREAK) begin
					`TB_CHK("break", v, ctrl[c].break_len)
				end
				if (a == `UURB_A_DRV) begin
					drv_b = v;
				end
			end
			// resume after the write sequence, reserved bits zero
			go(`UURB_RT_VWR, {chb, `UURB_A_ENABLE}, 16'h0003);
			`TB_CHK("rx_en", 1'b1, ctrl[c].rx_en)
			go(`UURB_RT_VRD, {chb, `UURB_A_ENABLE}, 16'h0000);
			`TB_CHK("enable_rd", 16'h0003, r.data)
		end
		// bit 0 alone is the transmitter
		go(`UURB_RT_VWR, {`UURB_CH_A, `UURB_A_ENABLE}, 16'h0001);
		`TB_CHK("tx_only", 2'b10, {ctrl[0].tx_en, ctrl[0].rx_en})
		// pin set and clear accepted while enabled
		v = rnd() & 16'h03FF;
		go(`UURB_RT_VWR, {`UURB_CH_A, `UURB_A_PSET}, v);
		`TB_CHK("pin_set", v[9:0], ctrl[0].pin_out)
		go(`UURB_RT_VRD, {`UURB_CH_A, `UURB_A_PSET}, 16'h0000);
		`TB_CHK("pset_rd", 16'h0000, r.data)
		go(`UURB_RT_VWR, {`UURB_CH_A, `UURB_A_PCLR}, v);
		`TB_CHK("pin_clr", 10'h000, ctrl[0].pin_out)
		// holes in the map and a channel that does not exist
		go(`UURB_RT_VRD, {`UURB_CH_A, 8'h01}, 16'h0000);
		`TB_CHK("unmapped", 16'h0000, r.data)
		xb = ctrl[1].xon;
		go(`UURB_RT_VWR, {8'h01, `UURB_A_XON}, 16'h00A5);
		`TB_CHK("bad_ch_wr", xb, ctrl[1].xon)
		go(`UURB_RT_VRD, {8'h01, `UURB_A_XON}, 16'h0000);
		`TB_CHK("bad_ch_rd", 16'h0000, r.data)
		// revision and link status only by their own requests
		go(`UURB_RT_DEV_IN, `UURB_IX_REV, 16'h0000);
		`TB_CHK("revision", REV, r.data)
		go(`UURB_RT_VRD, `UURB_IX_REV, 16'h0000);
		// channel byte 2 makes this the second channel's driver flag
		`TB_CHK("rev_generic", drv_b, r.data)
		v = rnd() & `UURB_LINK_MASK;
		go(`UURB_RT_DEV_OUT, `UURB_IX_LINK, v);
		`TB_CHK("link_wr", v & `UURB_LINK_MASK, link_status)
		go(`UURB_RT_VWR, `UURB_IX_LINK, ~v);
		`TB_CHK("link_generic", v & `UURB_LINK_MASK, link_status)
		go(`UURB_RT_DEV_IN, `UURB_IX_LINK, 16'h0000);
		`TB_CHK("link_rd", v & `UURB_LINK_MASK, r.data)
		go(8'h22, 16'h0000, 16'h0000);
		`TB_CHK("stall", 1'b0, r.ack)
		// error flags gather events and clear on read
		ev = 4'(rnd());
		ev[0] = 1'b1;
		@(posedge sys_clk);
		#2;
		line[0].err_ev = ev;
		line[0].break_live = 1'b1;
		@(posedge sys_clk);
		#2;
		line[0].err_ev = 4'h0;
		go(`UURB_RT_VRD, {`UURB_CH_A, `UURB_A_ERR}, 16'h0000);
		`TB_CHK("err", {8'h00, 1'b1, ev, 3'h0}, r.data)
		go(`UURB_RT_VRD, {`UURB_CH_A, `UURB_A_ERR}, 16'h0000);
		`TB_CHK("err_clr", 16'h0080, r.data)
		go(`UURB_RT_VRD, {`UURB_CH_B, `UURB_A_ERR}, 16'h0000);
		`TB_CHK("err_b", 16'h0000, r.data)
		// read-only levels and counts
		go(`UURB_RT_VRD, {`UURB_CH_A, `UURB_A_PLVL}, 16'h0000);
		`TB_CHK("pin_lvl", {4'h0, line[0].pin_level}, r.data)
		go(`UURB_RT_VWR, {`UURB_CH_A, `UURB_A_ENABLE}, 16'h0000);
		go(`UURB_RT_VWR, {`UURB_CH_A, `UURB_A_TXCNT}, 16'hFFFF);
		go(`UURB_RT_VWR, {`UURB_CH_A, `UURB_A_ENABLE}, 16'h0001);
		go(`UURB_RT_VRD, {`UURB_CH_A, `UURB_A_TXCNT}, 16'h0000);
		`TB_CHK("tx_cnt", {6'h00, line[0].tx_cnt}, r.data)
		go(`UURB_RT_VRD, {`UURB_CH_B, `UURB_A_RXCNT}, 16'h0000);
		`TB_CHK("rx_cnt", {6'h00, line[1].rx_cnt}, r.data)
		print_verdict();
	end
endmodule
